/* File: duart_channel.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - write strobe fall latches bus into register
// - output-select bit drives irq, clears user output
// - user output high after reset
// - reset clears host registers, outputs go to idle levels
// - serial in and out disabled in reset
// - ring indicator rise raises modem interrupt
// - rts bit one drives rts low
// - rts high after reset
// - cts stalls transmit only with auto cts
// - loopback ignores rx, feeds tx back
// - rx ready low at trigger or timeout
// - rx ready high on error, or when empty with the timeout flag clear
// - tx ready low with TRIG or more entries free, high with fewer
// - three sample majority vote per bit
// - vote applies to every received bit
// - read strobe fall drives selected register
// - irq output high impedance after reset
// - bit zero is first serial bit
module duart_channel #(
  parameter int DEPTH  = 64,
  parameter int TRIG   = 1
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // host bus
  input  wire logic [2:0] addr,
  input  wire logic       channel_select_n,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  // serial and modem
  input  wire logic       rx_in,
  output logic            tx_out,
  output logic            rts_n,
  output logic            dtr_n,
  input  wire logic       cts_n,
  input  wire logic       ring_indicator_n,
  // status pins
  output logic            user_output,
  output logic            irq_out,
  output logic            irq_oe,
  output logic            rx_dma_ready_n,
  output logic            tx_dma_ready_n
);
  localparam int AW = $clog2(DEPTH);
  localparam int BIT_CYC = duart_pkg::SAMPLES_PER_BIT;

  typedef enum {RX_IDLE, RX_BITS} duart_rx_type;
  typedef enum {TX_IDLE, TX_BITS} duart_tx_type;

  // host registers
  logic [7:0] ier_ff, lcr_ff, mcr_ff, efr_ff, nxt_ier, nxt_lcr, nxt_mcr, nxt_efr;
  logic       wr_d_ff, rd_d_ff, ri_d_ff, ms_ff, nxt_ms;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       oe_ff, nxt_oe;
  logic       wr_fall, rd_fall;

  assign wr_fall = wr_d_ff && !write_strobe_n && !channel_select_n;
  assign rd_fall = rd_d_ff && !read_strobe_n && !channel_select_n;

  // fifos: rx keeps an error flag alongside each byte
  logic [8:0] rx_mem [DEPTH];
  logic [7:0] tx_mem [DEPTH];
  logic [AW:0] rx_cnt_ff, tx_cnt_ff, nxt_rx_cnt, nxt_tx_cnt;
  logic [AW-1:0] rx_wp_ff, rx_rp_ff, tx_wp_ff, tx_rp_ff;
  logic [AW-1:0] nxt_rx_wp, nxt_rx_rp, nxt_tx_wp, nxt_tx_rp;
  logic          rx_push, tx_pop, rx_pop, tx_push;
  logic [8:0]    rx_word;

  // receiver
  duart_rx_type rx_st_ff, nxt_rx_st;
  logic [3:0]  rx_ph_ff, nxt_rx_ph;
  logic [3:0]  rx_bit_ff, nxt_rx_bit;
  logic [9:0]  rx_sh_ff, nxt_rx_sh;
  logic [9:0]  idle_ff, nxt_idle;
  logic        rx_line, voted, take, vclear, tmo_ff, nxt_tmo;

  // transmitter
  duart_tx_type tx_st_ff, nxt_tx_st;
  logic [3:0]  tx_ph_ff, nxt_tx_ph;
  logic [3:0]  tx_bit_ff, nxt_tx_bit;
  logic [9:0]  tx_sh_ff, nxt_tx_sh;
  logic        txd_ff, nxt_txd;

  // loopback swaps the pin for our own transmit line
  assign rx_line = mcr_ff[duart_pkg::MCR_LOOP_BIT] ? txd_ff : rx_in;
  assign take    = (rx_st_ff == RX_BITS) && (rx_ph_ff >= 4'(duart_pkg::VOTE_FIRST))
                   && (rx_ph_ff < 4'(duart_pkg::VOTE_FIRST + duart_pkg::VOTE_SAMPLES));
  assign vclear  = (rx_st_ff != RX_BITS) || (rx_ph_ff == 4'(BIT_CYC - 1));

  duart_vote i_duart_vote (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .sample_in (rx_line),
    .take      (take),
    .clear     (vclear),
    .level     (voted)
  );

  always_comb begin
    nxt_ier = ier_ff;
    nxt_lcr = lcr_ff;
    nxt_mcr = mcr_ff;
    nxt_efr = efr_ff;
    tx_push = 1'b0;
    if (wr_fall) begin
      case (addr)
        duart_pkg::REG_DATA: tx_push = (tx_cnt_ff != (AW+1)'(DEPTH));
        duart_pkg::REG_IER:  nxt_ier = data_in;
        duart_pkg::REG_LCR:  nxt_lcr = data_in;
        duart_pkg::REG_MCR:  nxt_mcr = data_in;
        duart_pkg::REG_EFR:  nxt_efr = data_in;
        default: ;
      endcase
    end
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_oe    = oe_ff;
    rx_pop    = 1'b0;
    nxt_ms    = ms_ff;
    // a ring edge in the same cycle as the read still sets
    if (rd_fall && addr == duart_pkg::REG_MSR) begin
      nxt_ms = 1'b0;
    end
    if (ri_d_ff == 1'b0 && ring_indicator_n == 1'b1) begin
      nxt_ms = 1'b1;
    end
    if (!read_strobe_n && !channel_select_n) begin
      nxt_oe = 1'b1;
    end else begin
      nxt_oe = 1'b0;
    end
    if (rd_fall) begin
      case (addr)
        duart_pkg::REG_DATA: begin
          nxt_rdata = rx_mem[rx_rp_ff][7:0];
          rx_pop    = (rx_cnt_ff != '0);
        end
        duart_pkg::REG_IER: nxt_rdata = ier_ff;
        duart_pkg::REG_LCR: nxt_rdata = lcr_ff;
        duart_pkg::REG_MCR: nxt_rdata = mcr_ff;
        duart_pkg::REG_LSR: nxt_rdata = {2'h0, tx_cnt_ff == '0, 3'h0, tmo_ff, rx_cnt_ff != '0};
        duart_pkg::REG_MSR: nxt_rdata = {1'b0, !ring_indicator_n, 1'b0, !cts_n, 3'h0, ms_ff};
        duart_pkg::REG_EFR: nxt_rdata = efr_ff;
        default:            nxt_rdata = duart_pkg::REG_RESET;
      endcase
    end
  end

  always_comb begin
    nxt_rx_st  = rx_st_ff;
    nxt_rx_ph  = rx_ph_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh  = rx_sh_ff;
    nxt_idle   = idle_ff;
    nxt_tmo    = tmo_ff;
    rx_push    = 1'b0;
    rx_word    = {1'b0, rx_sh_ff[8:1]};
    if (rx_pop) begin
      nxt_tmo  = 1'b0;
      nxt_idle = '0;
    end
    case (rx_st_ff)
      RX_IDLE: begin
        nxt_rx_ph  = 4'h0;
        nxt_rx_bit = 4'h0;
        if (!rx_line) begin
          nxt_rx_st = RX_BITS;
        end else if (rx_cnt_ff != '0) begin
          // timeout counts idle clocks, up to 40 bit times, with data waiting
          if (idle_ff == 10'(duart_pkg::RX_TIMEOUT_BITS * BIT_CYC)) begin
            nxt_tmo = 1'b1;
          end else begin
            nxt_idle = idle_ff + 10'h1;
          end
        end
      end
      RX_BITS: begin
        nxt_idle  = '0;
        nxt_rx_ph = rx_ph_ff + 4'h1;
        if (rx_ph_ff == 4'(BIT_CYC - 1)) begin
          nxt_rx_sh  = {voted, rx_sh_ff[9:1]};
          nxt_rx_bit = rx_bit_ff + 4'h1;
          if (rx_bit_ff == 4'h0 && voted) begin
            nxt_rx_st = RX_IDLE; // false start rejected by vote
          end else if (rx_bit_ff == 4'h9) begin
            rx_push   = (rx_cnt_ff != (AW+1)'(DEPTH));
            rx_word   = {!voted, rx_sh_ff[9:2]}; // missing stop marks framing error
            nxt_rx_st = RX_IDLE;
          end
        end
      end
      default: nxt_rx_st = RX_IDLE;
    endcase
  end

  always_comb begin
    nxt_tx_st  = tx_st_ff;
    nxt_tx_ph  = tx_ph_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_sh  = tx_sh_ff;
    nxt_txd    = txd_ff;
    tx_pop     = 1'b0;
    case (tx_st_ff)
      TX_IDLE: begin
        nxt_txd = 1'b1;
        // auto cts gating only when enabled; plain rts bit never stalls
        if (tx_cnt_ff != '0 && !(efr_ff[duart_pkg::EFR_ACTS_BIT] && cts_n)) begin
          tx_pop     = 1'b1;
          nxt_tx_sh  = {1'b1, tx_mem[tx_rp_ff], 1'b0};
          nxt_tx_ph  = 4'h0;
          nxt_tx_bit = 4'h0;
          nxt_tx_st  = TX_BITS;
        end
      end
      TX_BITS: begin
        nxt_txd   = tx_sh_ff[0];
        nxt_tx_ph = tx_ph_ff + 4'h1;
        if (tx_ph_ff == 4'(BIT_CYC - 1)) begin
          nxt_tx_sh  = {1'b1, tx_sh_ff[9:1]};
          nxt_tx_bit = tx_bit_ff + 4'h1;
          if (tx_bit_ff == 4'h9) begin
            nxt_tx_st = TX_IDLE;
          end
        end
      end
      default: nxt_tx_st = TX_IDLE;
    endcase
  end

  always_comb begin
    nxt_rx_wp  = rx_push ? rx_wp_ff + AW'(1) : rx_wp_ff;
    nxt_rx_rp  = rx_pop ? rx_rp_ff + AW'(1) : rx_rp_ff;
    nxt_rx_cnt = rx_cnt_ff + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    nxt_tx_wp  = tx_push ? tx_wp_ff + AW'(1) : tx_wp_ff;
    nxt_tx_rp  = tx_pop ? tx_rp_ff + AW'(1) : tx_rp_ff;
    nxt_tx_cnt = tx_cnt_ff + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
  end

  always_ff @(posedge clk_sys) begin
    if (rx_push) begin
      rx_mem[rx_wp_ff] <= rx_word;
    end
    if (tx_push) begin
      tx_mem[tx_wp_ff] <= data_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ier_ff    <= duart_pkg::REG_RESET;
      lcr_ff    <= duart_pkg::REG_RESET;
      mcr_ff    <= duart_pkg::MCR_RESET;
      efr_ff    <= duart_pkg::REG_RESET;
      wr_d_ff   <= 1'b1;
      rd_d_ff   <= 1'b1;
      ri_d_ff   <= 1'b1;
      ms_ff     <= 1'b0;
      rdata_ff  <= duart_pkg::REG_RESET;
      oe_ff     <= 1'b0;
      rx_st_ff  <= RX_IDLE;
      rx_ph_ff  <= 4'h0;
      rx_bit_ff <= 4'h0;
      rx_sh_ff  <= '0;
      idle_ff   <= '0;
      tmo_ff    <= 1'b0;
      tx_st_ff  <= TX_IDLE;
      tx_ph_ff  <= 4'h0;
      tx_bit_ff <= 4'h0;
      tx_sh_ff  <= '1;
      txd_ff    <= 1'b1;
      rx_wp_ff  <= '0;
      rx_rp_ff  <= '0;
      rx_cnt_ff <= '0;
      tx_wp_ff  <= '0;
      tx_rp_ff  <= '0;
      tx_cnt_ff <= '0;
    end else begin
      ier_ff    <= nxt_ier;
      lcr_ff    <= nxt_lcr;
      mcr_ff    <= nxt_mcr;
      efr_ff    <= nxt_efr;
      wr_d_ff   <= write_strobe_n;
      rd_d_ff   <= read_strobe_n;
      ri_d_ff   <= ring_indicator_n;
      ms_ff     <= nxt_ms;
      rdata_ff  <= nxt_rdata;
      oe_ff     <= nxt_oe;
      rx_st_ff  <= nxt_rx_st;
      rx_ph_ff  <= nxt_rx_ph;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff  <= nxt_rx_sh;
      idle_ff   <= nxt_idle;
      tmo_ff    <= nxt_tmo;
      tx_st_ff  <= nxt_tx_st;
      tx_ph_ff  <= nxt_tx_ph;
      tx_bit_ff <= nxt_tx_bit;
      tx_sh_ff  <= nxt_tx_sh;
      txd_ff    <= nxt_txd;
      rx_wp_ff  <= nxt_rx_wp;
      rx_rp_ff  <= nxt_rx_rp;
      rx_cnt_ff <= nxt_rx_cnt;
      tx_wp_ff  <= nxt_tx_wp;
      tx_rp_ff  <= nxt_tx_rp;
      tx_cnt_ff <= nxt_tx_cnt;
    end
  end

  // pin outputs
  logic rx_err_head, irq_cond;
  assign rx_err_head = (rx_cnt_ff != '0) && rx_mem[rx_rp_ff][8];
  assign irq_cond = (ier_ff[duart_pkg::IER_RX_BIT] && rx_cnt_ff != '0)
                  || (ier_ff[duart_pkg::IER_TX_BIT] && tx_cnt_ff == '0)
                  || (ier_ff[duart_pkg::IER_MS_BIT] && ms_ff);

  assign data_out    = rdata_ff;
  assign data_oe     = oe_ff;
  // loopback holds the pin idle high while looping internally
  assign tx_out      = mcr_ff[duart_pkg::MCR_LOOP_BIT] ? 1'b1 : txd_ff;
  assign rts_n       = !mcr_ff[duart_pkg::MCR_RTS_BIT];
  assign dtr_n       = !mcr_ff[duart_pkg::MCR_DTR_BIT];
  assign user_output = !mcr_ff[duart_pkg::MCR_OUT_BIT];
  assign irq_oe      = mcr_ff[duart_pkg::MCR_OUT_BIT];
  assign irq_out     = irq_cond;
  assign rx_dma_ready_n = !(((rx_cnt_ff >= (AW+1)'(TRIG)) || tmo_ff) && !rx_err_head);
  assign tx_dma_ready_n = !((DEPTH - int'(tx_cnt_ff)) >= TRIG);
endmodule : duart_channel
`default_nettype wire

/* File: duart_pkg.sv */
package duart_pkg;
  // register indices on a0..a2
  localparam logic [2:0] REG_DATA   = 3'h0;
  localparam logic [2:0] REG_IER    = 3'h1;
  localparam logic [2:0] REG_FCR    = 3'h2;
  localparam logic [2:0] REG_LCR    = 3'h3;
  localparam logic [2:0] REG_MCR    = 3'h4;
  localparam logic [2:0] REG_LSR    = 3'h5;
  localparam logic [2:0] REG_MSR    = 3'h6;
  localparam logic [2:0] REG_EFR    = 3'h7;
  // modem control, efr and ier fields, reset values
  localparam int MCR_DTR_BIT  = 0;
  localparam int MCR_RTS_BIT  = 1;
  localparam int MCR_OUT_BIT  = 3;
  localparam int MCR_LOOP_BIT = 4;
  localparam int EFR_ARTS_BIT = 6;
  localparam int EFR_ACTS_BIT = 7;
  localparam int IER_RX_BIT   = 0;
  localparam int IER_TX_BIT   = 1;
  localparam int IER_MS_BIT   = 3;
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  // timing
  localparam int SAMPLES_PER_BIT = 16;
  localparam int VOTE_FIRST      = 7;
  localparam int VOTE_SAMPLES    = 3;
  localparam int RX_TIMEOUT_BITS = 40;
  localparam logic [15:0] DIVISOR_RESET = 16'h0001;
endpackage : duart_pkg

/* File: duart_vote.sv */
`timescale 1ns/1ps
`default_nettype none
module duart_vote (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // sample control
  input  wire logic sample_in,
  input  wire logic take,
  input  wire logic clear,
  // result
  output logic      level
);
  logic [1:0] ones_ff;
  logic [1:0] nxt_ones;

  always_comb begin
    nxt_ones = ones_ff;
    if (clear) begin
      nxt_ones = 2'h0;
    end else if (take && sample_in) begin
      nxt_ones = ones_ff + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ones_ff <= 2'h0;
    end else begin
      ones_ff <= nxt_ones;
    end
  end

  // two of three samples high decides a one
  assign level = ones_ff[1];
endmodule : duart_vote
`default_nettype wire

/* File: duart_channel_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module duart_channel_sva #(
  parameter int DEPTH = 64,
  parameter int TRIG  = 1
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // host bus
  input wire logic [2:0] addr,
  input wire logic       channel_select_n,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic [7:0] data_in,
  input wire logic       data_oe,
  // pins
  input wire logic       tx_out,
  input wire logic       rts_n,
  input wire logic       user_output,
  input wire logic       irq_oe,
  input wire logic       rx_dma_ready_n,
  input wire logic       tx_dma_ready_n
);
  logic wr_prev_ff;
  logic loop_ff;
  logic nxt_wr_prev;
  logic nxt_loop;
  logic mcr_wr;
  // a write counts only on the sampled falling edge while selected
  assign mcr_wr = wr_prev_ff && !write_strobe_n && !channel_select_n
                  && addr == duart_pkg::REG_MCR;
  always_comb begin
    nxt_wr_prev = reset ? 1'b1 : write_strobe_n;
    nxt_loop    = reset ? 1'b0 : (mcr_wr ? data_in[duart_pkg::MCR_LOOP_BIT] : loop_ff);
  end
  always_ff @(posedge clk_sys) begin
    wr_prev_ff <= nxt_wr_prev;
    loop_ff    <= nxt_loop;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // reset itself is the cause here, so it cannot disable the check
  AST_RESET_OUT: assert property (disable iff (1'b0) reset |=> rts_n && user_output
    && !irq_oe && tx_out && rx_dma_ready_n && tx_dma_ready_n == (DEPTH < TRIG))
    else $error("outputs not reset");
  AST_RTS_WR: assert property (mcr_wr |=>
    rts_n == !$past(data_in[duart_pkg::MCR_RTS_BIT]))
    else $error("rts does not follow write");
  AST_OUT_WR: assert property (mcr_wr |=>
    user_output == !$past(data_in[duart_pkg::MCR_OUT_BIT])
    && irq_oe == $past(data_in[duart_pkg::MCR_OUT_BIT]))
    else $error("user output or irq drive wrong");
  AST_RTS_HOLD: assert property (!mcr_wr |=> $stable(rts_n))
    else $error("rts moved without write");
  AST_OUT_HOLD: assert property (!mcr_wr |=> $stable(user_output) && $stable(irq_oe))
    else $error("user output moved without write");
  AST_LOOP_TX: assert property (loop_ff && $past(loop_ff) |-> tx_out)
    else $error("tx pin active in loopback");
  AST_OE_ON: assert property ($fell(read_strobe_n) && !channel_select_n |=> data_oe)
    else $error("bus not driven on read");
  AST_OE_OFF: assert property ($rose(read_strobe_n) |=> !data_oe)
    else $error("bus still driven after read");
  AST_TX_START: assert property ($fell(tx_out) |-> (!tx_out)[*8] ##1 (!tx_out)[*8])
    else $error("start bit too short");
endmodule : duart_channel_sva
bind duart_channel duart_channel_sva #(.DEPTH(DEPTH), .TRIG(TRIG)) i_duart_channel_sva (
  .clk_sys, .reset, .addr, .channel_select_n, .write_strobe_n, .read_strobe_n, .data_in,
  .data_oe, .tx_out, .rts_n, .user_output, .irq_oe, .rx_dma_ready_n, .tx_dma_ready_n);
`default_nettype wire

/* File: duart_host.sv */
`timescale 1ns/1ps
`default_nettype none
module duart_host (
  // clock
  input  wire logic       clk_sys,
  // bus
  output logic      [2:0] addr,
  output logic            channel_select_n,
  output logic            write_strobe_n,
  output logic            read_strobe_n,
  output logic      [7:0] data_in,
  input  wire logic [7:0] data_out
);
  int hold_cyc = 0;
  initial {addr, data_in, channel_select_n, write_strobe_n, read_strobe_n} = {11'h000, 3'h7};
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic sel_n = 1'b0);
    @(negedge clk_sys);
    {addr, data_in, channel_select_n, write_strobe_n} = {a, d, sel_n, 1'b0};
    repeat (1 + hold_cyc) @(negedge clk_sys);
    {channel_select_n, write_strobe_n} = 2'h3;
    // released bus must not look like the last value
    data_in = ~d;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    {addr, channel_select_n, read_strobe_n} = {a, 2'h0};
    repeat (2 + hold_cyc) @(negedge clk_sys);
    d = data_out;
    {channel_select_n, read_strobe_n} = 2'h3;
  endtask : rd
endmodule : duart_host
`default_nettype wire

/* File: duart_channel_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module duart_channel_tb;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic [2:0] addr;
  logic       channel_select_n, write_strobe_n, read_strobe_n, data_oe;
  logic [7:0] data_in, data_out, r;
  logic       rx_in = 1'b1;
  logic       cts_n = 1'b0;
  logic       ring_indicator_n = 1'b1;
  logic       tx_out, rts_n, dtr_n, user_output, irq_out, irq_oe;
  logic       rx_dma_ready_n, tx_dma_ready_n;
  int         n_errors = 0;
  int         n_checks = 0;
  duart_channel #(.DEPTH(64), .TRIG(1)) i_duart_channel (.clk_sys, .reset, .addr,
    .channel_select_n, .write_strobe_n, .read_strobe_n, .data_in, .data_out, .data_oe,
    .rx_in, .tx_out, .rts_n, .dtr_n, .cts_n, .ring_indicator_n, .user_output, .irq_out,
    .irq_oe, .rx_dma_ready_n, .tx_dma_ready_n);
  duart_host i_duart_host (.clk_sys, .addr, .channel_select_n, .write_strobe_n,
    .read_strobe_n, .data_in, .data_out);
  always #5 clk_sys = ~clk_sys;
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk1(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %b", $time, m, got);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk8
  task automatic bail(input string m);
    n_errors++;
    $display("BAD %0t timeout %s", $time, m);
    wrap_up();
  endtask : bail
  task automatic do_reset;
    @(negedge clk_sys);
    reset = 1'b1;
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
  endtask : do_reset
  task automatic wait_rx_ready;
    for (int i = 0; i < 200 && rx_dma_ready_n; i++) @(negedge clk_sys);
    if (rx_dma_ready_n) bail("rx ready");
  endtask : wait_rx_ready
  // one glitch sample mid-bit on every bit, start and stop included
  task automatic send_byte(input logic [7:0] b, input logic stop = 1'b1);
    logic [9:0] fr;
    fr = {stop, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      for (int c = 0; c < 16; c++) begin
        @(negedge clk_sys);
        rx_in = (c == 8) ? ~fr[k] : fr[k];
      end
    end
  endtask : send_byte
  task automatic get_frame(input logic [7:0] exp);
    for (int i = 0; i < 500 && tx_out; i++) @(negedge clk_sys);
    if (tx_out) bail("no frame");
    repeat (8) @(negedge clk_sys);
    chk1(tx_out, 1'b0, "start bit");
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(negedge clk_sys);
      chk1(tx_out, exp[i], "data bit");
    end
    repeat (16) @(negedge clk_sys);
    chk1(tx_out, 1'b1, "stop bit");
  endtask : get_frame
  task automatic t_reset;
    chk1(rts_n, 1'b1, "rts");
    chk1(user_output, 1'b1, "user out");
    chk1(irq_oe, 1'b0, "irq drive");
    chk1(tx_out, 1'b1, "tx idle");
    chk1(rx_dma_ready_n, 1'b1, "rx ready");
    chk1(tx_dma_ready_n, 1'b0, "tx ready");
    i_duart_host.rd(duart_pkg::REG_MCR, r);
    chk8(r, duart_pkg::MCR_RESET, "mcr reset");
  endtask : t_reset
  task automatic t_mcr;
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      v = {4'h0, k[1], 1'b0, k[0], 1'b0};
      i_duart_host.hold_cyc = k;
      i_duart_host.wr(duart_pkg::REG_MCR, v);
      @(negedge clk_sys);
      chk1(rts_n, ~v[1], "rts");
      chk1(user_output, ~v[3], "user out");
      chk1(irq_oe, v[3], "irq drive");
      i_duart_host.wr(duart_pkg::REG_MCR, ~v, 1'b1);
      @(negedge clk_sys);
      chk1(rts_n, ~v[1], "deselected write");
      i_duart_host.rd(duart_pkg::REG_MCR, r);
      chk8(r, v, "mcr readback");
    end
    i_duart_host.hold_cyc = 0;
  endtask : t_mcr
  task automatic t_tx;
    i_duart_host.wr(duart_pkg::REG_DATA, 8'h3c);
    i_duart_host.wr(duart_pkg::REG_DATA, 8'hc1);
    get_frame(8'h3c);
    get_frame(8'hc1);
  endtask : t_tx
  task automatic t_rx;
    send_byte(8'ha5);
    wait_rx_ready();
    chk1(rx_dma_ready_n, 1'b0, "rx ready");
    i_duart_host.rd(duart_pkg::REG_DATA, r);
    chk8(r, 8'ha5, "rx byte");
    repeat (2) @(negedge clk_sys);
    chk1(rx_dma_ready_n, 1'b1, "rx ready empty");
  endtask : t_rx
  // low stop marks the first byte bad; the good one behind it must wait
  task automatic t_ferr;
    send_byte(8'h96, 1'b0);
    send_byte(8'h69);
    repeat (4) @(negedge clk_sys);
    chk1(rx_dma_ready_n, 1'b1, "rx ready error head");
    i_duart_host.rd(duart_pkg::REG_DATA, r);
    chk8(r, 8'h96, "error byte");
    chk1(rx_dma_ready_n, 1'b0, "rx ready next byte");
    i_duart_host.rd(duart_pkg::REG_DATA, r);
    chk8(r, 8'h69, "byte after error");
    repeat (2) @(negedge clk_sys);
    chk1(rx_dma_ready_n, 1'b1, "rx ready drained");
  endtask : t_ferr
  task automatic t_loop;
    i_duart_host.wr(duart_pkg::REG_MCR, 8'h10);
    i_duart_host.wr(duart_pkg::REG_DATA, 8'h5a);
    send_byte(8'h0f);
    wait_rx_ready();
    chk1(tx_out, 1'b1, "tx pin in loop");
    i_duart_host.rd(duart_pkg::REG_DATA, r);
    chk8(r, 8'h5a, "looped byte");
    i_duart_host.wr(duart_pkg::REG_MCR, 8'h00);
  endtask : t_loop
  task automatic pulse_ring(input logic exp);
    @(negedge clk_sys);
    ring_indicator_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk1(irq_out, 1'b0, "irq on ring fall");
    ring_indicator_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    chk1(irq_out, exp, "irq on ring rise");
  endtask : pulse_ring
  task automatic t_ring;
    i_duart_host.wr(duart_pkg::REG_MCR, 8'h08);
    pulse_ring(1'b0);
    i_duart_host.rd(duart_pkg::REG_MSR, r);
    chk1(r[0], 1'b1, "ring status latched");
    i_duart_host.wr(duart_pkg::REG_IER, 8'h08);
    pulse_ring(1'b1);
    i_duart_host.rd(duart_pkg::REG_MSR, r);
    repeat (2) @(negedge clk_sys);
    chk1(irq_out, 1'b0, "irq after status read");
  endtask : t_ring
  task automatic t_full;
    int n;
    for (n = 0; n < 70 && !tx_dma_ready_n; n++) i_duart_host.wr(duart_pkg::REG_DATA, n[7:0]);
    chk1(n >= 64 && n <= 65, 1'b1, "fill count");
    chk1(tx_dma_ready_n, 1'b1, "tx ready full");
    // reset in mid-transmission
    do_reset();
  endtask : t_full
  initial begin
    do_reset();
    t_reset();
    t_mcr();
    t_tx();
    t_rx();
    t_ferr();
    t_loop();
    t_ring();
    t_full();
    t_reset();
    wrap_up();
  end
endmodule : duart_channel_tb
`default_nettype wire
